// ### design/emx_cfg_regs.sv
// Purpose: Configuration, SDRAM timing and refresh timer registers over APB.
// Assumes: One 50 MHz clock; the memory sequencer reports its commands.
// Notes: Memory-interface cycles are the half-rate clock enable.
`timescale 1ns/1ns
`default_nettype none
module emx_cfg_regs import emx_pkg::*; (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        act_cmd_i,
    input  wire logic        pre_cmd_i,
    input  wire logic        ref_cmd_i,
    input  wire logic        read_rise_i,
    input  wire logic [1:0]  read_space_i,
    input  wire logic        refresh_ack_i,
    output logic             half_rate_clock_out_o,
    output logic [11:0]      memory_kind_select_o,
    output logic [95:0]      space_shape_o,
    output logic             column_width_select_o,
    output logic             refresh_enable_o,
    output logic [3:0]       sdram_init_o,
    output logic             refresh_event_o,
    output logic             bus_request_out_o,
    output logic             column_wait_o,
    output logic             precharge_wait_o,
    output logic             row_cycle_wait_o,
    output logic             read_hold_o,
    output logic             async_output_enable_hold_o
);
    logic [31:0] space_q [4];
    logic [31:0] sdram_control_q;
    logic [11:0] period_q;
    logic [11:0] cnt_q;
    logic        tick_q;
    logic [2:0]  sel_q;
    logic [31:0] rdata_d;
    logic [2:0]  sel_d;
    logic        wr_en;
    logic        expire;
    logic [4:0]  tmr_load [N_TMR];
    logic        tmr_start [N_TMR];
    logic        tmr_busy [N_TMR];
    logic [31:0] hold_reg;

    function automatic logic [2:0] dec_addr(input logic [7:0] a);
        logic [2:0] s;
        s = SEL_NONE;
        if (a == SPACE0_OFS) begin
            s = 3'h0;
        end else if (a == SPACE1_OFS) begin
            s = 3'h1;
        end else if (a == SPACE2_OFS) begin
            s = 3'h2;
        end else if (a == SPACE3_OFS) begin
            s = 3'h3;
        end else if (a == SDRAM_CONTROL_OFS) begin
            s = SEL_SDRAM_CONTROL;
        end else if (a == RTIM_OFS) begin
            s = SEL_RTIM;
        end
        return s;
    endfunction : dec_addr

    function automatic logic is_async(input logic [31:0] r);
        return r[KIND_LSB+:3] <= 3'(async_word_type);
    endfunction : is_async

    function automatic logic is_sdram(input logic [31:0] r);
        return r[KIND_LSB+:3] == 3'(sync_dram_word_type);
    endfunction : is_sdram

    // APB: decoded in the setup cycle, answered with one wait-free access.
    assign sel_d = dec_addr(paddr_i);
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        rdata_d = 32'h0;
        if (sel_d <= 3'h3) begin
            rdata_d = space_q[sel_d[1:0]] & SPACE_WMASK;
        end else if (sel_d == SEL_SDRAM_CONTROL) begin
            // The init bit is write-only and reads as zero.
            rdata_d = sdram_control_q & SDRAM_CONTROL_WMASK;
        end else if (sel_d == SEL_RTIM) begin
            rdata_d = {8'h0, cnt_q, period_q};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b0;
            sel_q     <= SEL_NONE;
        end else begin
            pready_o <= psel_i && !penable_i;
            if (psel_i && !penable_i) begin
                prdata_o  <= pwrite_i ? 32'h0 : rdata_d;
                pslverr_o <= (sel_d == SEL_NONE);
                sel_q     <= sel_d;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_space
            always_ff @(posedge ref_clk_i) begin
                if (!rst_b_i) begin
                    space_q[gi] <= SPACE_RESET;
                end else if (wr_en && sel_q == 3'(gi)) begin
                    space_q[gi] <= pwdata_i & SPACE_WMASK;
                end
            end
            always_ff @(posedge ref_clk_i) begin
                if (!rst_b_i) begin
                    memory_kind_select_o[gi*3+:3]  <= SPACE_RESET[KIND_LSB+:3];
                    space_shape_o[gi*24+:24]       <= 24'h0;
                end else begin
                    memory_kind_select_o[gi*3+:3] <= space_q[gi][KIND_LSB+:3];
                    // Synchronous spaces ignore the strobe shaping fields.
                    space_shape_o[gi*24+:24] <= is_async(space_q[gi]) ?
                                                space_q[gi][31:SHAPE_LSB] : 24'h0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sdram_control_q  <= SDRAM_CONTROL_RESET;
            period_q <= PERIOD_RESET;
        end else if (wr_en && sel_q == SEL_SDRAM_CONTROL) begin
            sdram_control_q <= pwdata_i & SDRAM_CONTROL_WMASK;
        end else if (wr_en && sel_q == SEL_RTIM) begin
            period_q <= pwdata_i[11:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            column_width_select_o <= 1'b0;
            refresh_enable_o      <= 1'b0;
        end else begin
            column_width_select_o <= sdram_control_q[COLW_BIT];
            refresh_enable_o      <= sdram_control_q[REFRESH_ENABLE_BIT];
        end
    end

    // Init pulse goes to every space whose kind is SDRAM.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sdram_init_o <= 4'h0;
        end else if (wr_en && sel_q == SEL_SDRAM_CONTROL && pwdata_i[INIT_BIT]) begin
            sdram_init_o <= {is_sdram(space_q[3]), is_sdram(space_q[2]),
                             is_sdram(space_q[1]), is_sdram(space_q[0])};
        end else begin
            sdram_init_o <= 4'h0;
        end
    end

    // The half-rate output defines one memory-interface cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            half_rate_clock_out_o <= 1'b0;
            tick_q                <= 1'b0;
        end else begin
            half_rate_clock_out_o <= !half_rate_clock_out_o;
            tick_q                <= !half_rate_clock_out_o;
        end
    end

    assign expire = tick_q && (cnt_q == 12'h0);

    // The timer runs regardless of refresh enable so it can serve as a
    // general periodic timer.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= PERIOD_RESET;
        end else if (expire) begin
            cnt_q <= period_q;
        end else if (tick_q) begin
            cnt_q <= cnt_q - 12'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            refresh_event_o <= 1'b0;
        end else begin
            refresh_event_o <= expire;
        end
    end

    // A new expiry with refresh enabled wins over an acknowledge in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            bus_request_out_o <= 1'b0;
        end else if (expire && sdram_control_q[REFRESH_ENABLE_BIT]) begin
            bus_request_out_o <= 1'b1;
        end else if (refresh_ack_i) begin
            bus_request_out_o <= 1'b0;
        end
    end

    // Timing guards. A command issued mid-cycle may lose up to half a
    // memory-interface cycle; the sequencer should issue on memory edges.
    assign hold_reg = space_q[read_space_i];

    always_comb begin
        tmr_load[T_RCD]   = 5'(sdram_control_q[RCD_LSB+:4]) + 5'h1;
        tmr_load[T_RP]    = 5'(sdram_control_q[RP_LSB+:4]) + 5'h1;
        tmr_load[T_RC]    = 5'(sdram_control_q[RC_LSB+:4]) + 5'h1;
        tmr_load[T_HOLD]  = 5'(hold_reg[HOLD_LSB+:2]);
        tmr_load[T_AOE]   = is_async(hold_reg) ? 5'(hold_reg[HOLD_LSB+:2]) : 5'h0;
        tmr_start[T_RCD]  = act_cmd_i;
        tmr_start[T_RP]   = pre_cmd_i;
        tmr_start[T_RC]   = act_cmd_i || ref_cmd_i;
        tmr_start[T_HOLD] = read_rise_i;
        tmr_start[T_AOE]  = read_rise_i;
    end

    generate
        for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
            emx_gap_timer u_tmr (
                .ref_clk_i (ref_clk_i),
                .rst_b_i   (rst_b_i),
                .tick_i    (tick_q),
                .start_i   (tmr_start[gi]),
                .load_i    (tmr_load[gi]),
                .busy_o    (tmr_busy[gi])
            );
        end
    endgenerate

    assign column_wait_o              = tmr_busy[T_RCD];
    assign precharge_wait_o           = tmr_busy[T_RP];
    assign row_cycle_wait_o           = tmr_busy[T_RC];
    assign read_hold_o                = tmr_busy[T_HOLD];
    assign async_output_enable_hold_o = tmr_busy[T_AOE];

    logic [5:0] rcd_len_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || !column_wait_o) begin
            rcd_len_q <= 6'h0;
        end else if (rcd_len_q != 6'h3F) begin
            rcd_len_q <= rcd_len_q + 6'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_SPACE_RESV: assert property (
        pready_o && sel_q <= 3'h3 |-> (prdata_o & ~SPACE_WMASK) == 32'h0)
        else $error("Reserved space bits read nonzero.");
    AST_SDRAM_CONTROL_RESV: assert property (
        pready_o && sel_q == SEL_SDRAM_CONTROL |-> (prdata_o & ~SDRAM_CONTROL_WMASK) == 32'h0)
        else $error("Reserved SDRAM control bits read nonzero.");
    AST_RTIM_CNT: assert property (
        psel_i && !penable_i && !pwrite_i && sel_d == SEL_RTIM
        |=> prdata_o == {8'h0, $past(cnt_q), $past(period_q)})
        else $error("Refresh timing read does not show live counter.");
    AST_RELOAD: assert property (
        expire |=> cnt_q == $past(period_q) && refresh_event_o)
        else $error("Counter did not reload with event.");
    AST_DECREMENT: assert property (
        tick_q && cnt_q != 12'h0 |=> cnt_q == $past(cnt_q) - 12'h1 && !refresh_event_o)
        else $error("Counter did not step down by one.");
    // A period of zero expires on every tick, so events may be two cycles apart.
    AST_EVENT_PULSE: assert property (
        refresh_event_o |=> !refresh_event_o)
        else $error("Refresh event longer than one cycle.");
    AST_BUS_REQUEST_OUT: assert property (
        $rose(bus_request_out_o) |-> $past(expire) && $past(sdram_control_q[REFRESH_ENABLE_BIT]))
        else $error("Bus request without enabled refresh expiry.");
    AST_RCD_LEN: assert property (
        $fell(column_wait_o) |-> rcd_len_q >= 6'(2 * sdram_control_q[RCD_LSB+:4] + 1))
        else $error("Row to column wait ended early.");
    AST_RC_START: assert property (
        act_cmd_i || ref_cmd_i |=> row_cycle_wait_o)
        else $error("Row cycle wait missing after activate or refresh.");
    AST_AOE_HOLD: assert property (
        read_rise_i && hold_reg[1:0] != 2'h0 |=>
        read_hold_o && async_output_enable_hold_o == $past(is_async(hold_reg)))
        else $error("Read hold or output enable hold wrong.");
    AST_INIT: assert property (
        wr_en && sel_q == SEL_SDRAM_CONTROL && pwdata_i[INIT_BIT] |=>
        sdram_init_o[0] == $past(is_sdram(space_q[0])))
        else $error("Init pulse does not follow memory kind.");
    AST_SHAPE: assert property (
        !is_async(space_q[1]) |=> space_shape_o[47:24] == 24'h0)
        else $error("Shaping fields leak for synchronous space.");
    // The first edge after reset still sees the reset level twice.
    AST_HALF_RATE: assert property (
        $past(rst_b_i) |-> half_rate_clock_out_o != $past(half_rate_clock_out_o))
        else $error("Half-rate clock output did not toggle.");
    AST_RCD_START: assert property (
        act_cmd_i |=> column_wait_o)
        else $error("Row to column wait missing after activate.");
    AST_RP_START: assert property (
        pre_cmd_i |=> precharge_wait_o)
        else $error("Precharge wait missing after precharge.");
    AST_BUS_REQUEST_OUT_HOLD: assert property (
        bus_request_out_o && !refresh_ack_i |=> bus_request_out_o)
        else $error("Bus request dropped before acknowledge.");
    AST_NO_REQ_DISABLED: assert property (
        !sdram_control_q[REFRESH_ENABLE_BIT] && !bus_request_out_o |=> !bus_request_out_o)
        else $error("Bus request raised while refresh disabled.");

    COV_EVENT: cover property (refresh_event_o);
    COV_BUS_REQUEST_OUT: cover property ($rose(bus_request_out_o));
    COV_INIT: cover property (sdram_init_o != 4'h0);
    COV_AOE: cover property (async_output_enable_hold_o);
    COV_GAP: cover property ($fell(column_wait_o));
endmodule : emx_cfg_regs
`default_nettype wire

// ### design/emx_pkg.sv
// Purpose: Shared constants for the memory interface configuration registers.
// Assumes: 32-bit APB data, byte offsets in an 8-bit window.
// Notes: Masks mark stored bits; every other bit reads as zero.
package emx_pkg;
    localparam logic [7:0]  SPACE0_OFS   = 8'h08;
    localparam logic [7:0]  SPACE1_OFS   = 8'h04;
    localparam logic [7:0]  SPACE2_OFS   = 8'h10;
    localparam logic [7:0]  SPACE3_OFS   = 8'h14;
    localparam logic [7:0]  SDRAM_CONTROL_OFS    = 8'h18;
    localparam logic [7:0]  RTIM_OFS     = 8'h1C;
    localparam logic [2:0]  SEL_SDRAM_CONTROL    = 3'h4;
    localparam logic [2:0]  SEL_RTIM     = 3'h5;
    localparam logic [2:0]  SEL_NONE     = 3'h7;
    localparam int          KIND_LSB     = 4;
    localparam int          HOLD_LSB     = 0;
    localparam int          SHAPE_LSB    = 8;
    localparam int          COLW_BIT     = 26;
    localparam int          REFRESH_ENABLE_BIT     = 25;
    localparam int          INIT_BIT     = 24;
    localparam int          RCD_LSB      = 20;
    localparam int          RP_LSB       = 16;
    localparam int          RC_LSB       = 12;
    localparam int          CNT_LSB      = 12;
    localparam logic [31:0] SPACE_WMASK  = 32'hFFFF3F73;
    localparam logic [31:0] SPACE_RESET  = 32'hFFFF3F23;
    localparam logic [31:0] SDRAM_CONTROL_WMASK  = 32'h06FFF000;
    localparam logic [31:0] SDRAM_CONTROL_RESET  = 32'h00000000;
    localparam logic [11:0] PERIOD_RESET = 12'h5DC;
    localparam int          T_RCD        = 0;
    localparam int          T_RP         = 1;
    localparam int          T_RC         = 2;
    localparam int          T_HOLD       = 3;
    localparam int          T_AOE        = 4;
    localparam int          N_TMR        = 5;
    typedef enum logic [2:0] {
        async_byte_type      = 3'h0,
        async_half_type      = 3'h1,
        async_word_type      = 3'h2,
        sync_dram_word_type  = 3'h3,
        burst_sram_word_type = 3'h4
    } emx_kind_type;
endpackage : emx_pkg

// ### design/emx_gap_timer.sv
// Purpose: Counts a loaded number of memory-interface cycles.
// Assumes: tick_i is a one-cycle pulse once per memory-interface cycle.
// Notes: A load of zero leaves the timer idle.
`timescale 1ns/1ns
`default_nettype none
module emx_gap_timer import emx_pkg::*; (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       tick_i,
    input  wire logic       start_i,
    input  wire logic [4:0] load_i,
    output logic            busy_o
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = load_i;
        end else if (tick_i && cnt_q != 5'h0) begin
            cnt_d = cnt_q - 5'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt_q  <= 5'h0;
            busy_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_o <= (cnt_d != 5'h0);
        end
    end
endmodule : emx_gap_timer
`default_nettype wire

// ### testbench/emx_seq_model.sv
// Purpose: Far-side model that answers refresh requests like the memory sequencer.
// Assumes: bus_request_out_i is a level that stays up until it is acknowledged.
// Notes: ack_delay_i sets how long the model waits before it serves a request.
`timescale 1ns/1ns
`default_nettype none
module emx_seq_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       bus_request_out_i,
    input  wire logic [3:0] ack_delay_i,
    output logic            ref_cmd_o,
    output logic            refresh_ack_o
);
    logic [3:0] wait_q;

    // The acknowledge is held back for one cycle after it is given, so that a request
    // which is still falling is not served twice.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            wait_q        <= 4'h0;
            ref_cmd_o     <= 1'b0;
            refresh_ack_o <= 1'b0;
        end else if (bus_request_out_i && !refresh_ack_o && wait_q >= ack_delay_i) begin
            wait_q        <= 4'h0;
            ref_cmd_o     <= 1'b1;
            refresh_ack_o <= 1'b1;
        end else begin
            wait_q        <= (bus_request_out_i && wait_q != 4'hF) ? wait_q + 4'h1 : 4'h0;
            ref_cmd_o     <= 1'b0;
            refresh_ack_o <= 1'b0;
        end
    end
endmodule : emx_seq_model
`default_nettype wire

// ### testbench/emx_cfg_regs_test.sv
// Purpose: Self-checking bench for the memory interface configuration registers.
// Assumes: Zero-wait APB slave; memory-interface ticks come every second clock.
// Notes: Read data expectations are queued by the driver and checked by a monitor.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, (e), (g)); end end
module emx_cfg_regs_test import emx_pkg::*;;
    logic        ref_clk_i;
    logic        rst_b_i;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv, d;
    logic        act, pre, rrise, ref_cmd, ack;
    logic [1:0]  rspace;
    logic [3:0]  ack_dly, init;
    logic        hrc, colw, refresh_enable, evt, breq, cw, pw, rw, rh, async_output_enable;
    logic [11:0] kind;
    logic [95:0] shape;
    logic [7:0]  ofs [4];
    logic [31:0] q_exp [$];
    logic [31:0] q_msk [$];
    logic        q_err [$];
    int          n_mismatch;
    int          samples_checked;
    int          seed;
    int          t;

    emx_cfg_regs dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .act_cmd_i(act),
        .pre_cmd_i(pre), .ref_cmd_i(ref_cmd), .read_rise_i(rrise), .read_space_i(rspace),
        .refresh_ack_i(ack), .half_rate_clock_out_o(hrc), .memory_kind_select_o(kind),
        .space_shape_o(shape), .column_width_select_o(colw), .refresh_enable_o(refresh_enable),
        .sdram_init_o(init), .refresh_event_o(evt), .bus_request_out_o(breq),
        .column_wait_o(cw), .precharge_wait_o(pw), .row_cycle_wait_o(rw),
        .read_hold_o(rh), .async_output_enable_hold_o(async_output_enable));

    emx_seq_model partner (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .bus_request_out_i(breq), .ack_delay_i(ack_dly), .ref_cmd_o(ref_cmd),
        .refresh_ack_o(ack));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // One APB transfer; the monitor checks the answer against the queued note.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] m, input logic [31:0] e, input logic err,
                       output logic [31:0] rd);
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        q_exp.push_back(e);
        q_msk.push_back(m);
        q_err.push_back(err);
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge ref_clk_i) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            `CHK("read data", q_exp[0], prdata & q_msk[0])
            `CHK("slave error", q_err[0], pslverr)
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
            void'(q_err.pop_front());
        end
    end

    function automatic logic gap_out(input int s);
        case (s)
            0: return cw;
            1: return rw;
            2: return pw;
            3: return rh;
            default: return async_output_enable;
        endcase
    endfunction : gap_out

    // Counts the cycles a gap output stays high after one command pulse.
    task automatic pulse_gap(input int sel, input int n);
        int c;
        c = 0;
        @(posedge ref_clk_i);
        act   <= (sel < 2);
        pre   <= (sel == 2);
        rrise <= (sel > 2);
        @(posedge ref_clk_i);
        act   <= 1'b0;
        pre   <= 1'b0;
        rrise <= 1'b0;
        repeat (80) begin
            @(posedge ref_clk_i);
            if (gap_out(sel) === 1'b1) c++;
        end
        `CHK("gap length", 1'b1, (c >= 2 * n - 1 && c <= 2 * n))
    endtask : pulse_gap

    task automatic wait_evt(output int n);
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (evt !== 1'b1 && n < 4000);
    endtask : wait_evt

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        complete_run();
    end

    initial begin
        seed = 26;
        n_mismatch = 0;
        samples_checked = 0;
        {psel, penable, pwrite, act, pre, rrise} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        rspace = 2'h0;
        ack_dly = 4'h5;
        rst_b_i = 1'b0;
        ofs = '{SPACE0_OFS, SPACE1_OFS, SPACE2_OFS, SPACE3_OFS};
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        `CHK("kind at reset", 12'h492, kind)
        @(posedge ref_clk_i);
        `CHK("half rate clock", 1'b1, hrc)
        apb(1'b0, SPACE0_OFS, 0, '1, SPACE_RESET, 1'b0, rdv);
        apb(1'b0, SDRAM_CONTROL_OFS, 0, '1, SDRAM_CONTROL_RESET, 1'b0, rdv);
        apb(1'b0, RTIM_OFS, 0, 32'hFF000FFF, {20'h0, PERIOD_RESET}, 1'b0, rdv);
        apb(1'b1, 8'h00, 32'hFFFFFFFF, 0, 0, 1'b1, rdv);
        apb(1'b0, 8'h0C, 0, '1, 0, 1'b1, rdv);
        for (int k = 0; k < 8; k++) begin
            d = $random(seed);
            d[6:4] = k[2:0];
            apb(1'b1, ofs[k % 4], d, 0, 0, 1'b0, rdv);
            repeat (2) @(posedge ref_clk_i);
            `CHK("kind", k[2:0], kind[3 * (k % 4) +: 3])
            rdv = (k >= 3) ? 32'h0 : (d & SPACE_WMASK);
            `CHK("shape", rdv[31:8], shape[24 * (k % 4) +: 24])
            apb(1'b0, ofs[k % 4], 0, '1, d & SPACE_WMASK, 1'b0, rdv);
        end
        // Every space is programmed before initialisation is started.
        apb(1'b1, SPACE0_OFS, 32'h00000022, 0, 0, 1'b0, rdv);
        apb(1'b1, SPACE1_OFS, 32'h00000030, 0, 0, 1'b0, rdv);
        apb(1'b1, SPACE2_OFS, 32'h00000001, 0, 0, 1'b0, rdv);
        apb(1'b1, SPACE3_OFS, 32'h00000030, 0, 0, 1'b0, rdv);
        apb(1'b1, SDRAM_CONTROL_OFS, 32'hFD241FFF, 0, 0, 1'b0, rdv);
        @(posedge ref_clk_i);
        `CHK("init pulse", 4'hA, init)
        @(posedge ref_clk_i);
        `CHK("init end", 4'h0, init)
        `CHK("column width", 1'b1, colw)
        `CHK("refresh enable", 1'b0, refresh_enable)
        apb(1'b0, SDRAM_CONTROL_OFS, 0, '1, 32'h04241000, 1'b0, rdv);
        pulse_gap(0, 3);
        pulse_gap(1, 2);
        pulse_gap(2, 5);
        pulse_gap(3, 2);
        pulse_gap(4, 2);
        rspace <= 2'h1;
        pulse_gap(4, 0);
        apb(1'b1, SDRAM_CONTROL_OFS, 32'h00F00000, 0, 0, 1'b0, rdv);
        pulse_gap(0, 16);
        `CHK("column width", 1'b0, colw)
        apb(1'b1, RTIM_OFS, 32'hFFFFF003, 0, 0, 1'b0, rdv);
        apb(1'b0, RTIM_OFS, 0, 32'hFF000FFF, 32'h00000003, 1'b0, rdv);
        apb(1'b1, SDRAM_CONTROL_OFS, 32'h02000000, 0, 0, 1'b0, rdv);
        ack_dly <= 4'h1;
        wait_evt(t);
        `CHK("request on expiry", 1'b1, breq)
        `CHK("refresh enable on", 1'b1, refresh_enable)
        wait_evt(t);
        `CHK("refresh interval", 8, t)
        @(posedge ref_clk_i);
        `CHK("event width", 1'b0, evt)
        repeat (3) @(posedge ref_clk_i);
        `CHK("request served", 1'b0, breq)
        // The setup cycle falls six cycles after the event, when the counter is zero.
        apb(1'b0, RTIM_OFS, 0, '1, 32'h00000003, 1'b0, rdv);
        `CHK("live counter", 12'h000, rdv[23:12])
        apb(1'b1, SDRAM_CONTROL_OFS, 32'h00000000, 0, 0, 1'b0, rdv);
        wait_evt(t);
        wait_evt(t);
        `CHK("timer without refresh", 8, t)
        `CHK("no request when disabled", 1'b0, breq)
        `CHK("pending reads", 0, q_exp.size())
        complete_run();
    end
endmodule : emx_cfg_regs_test
`default_nettype wire
